// file: hdl/smbhc_pkg.sv
// Purpose: shared constants and types of the SMBus host master.
// Assumes: 100 MHz system clock, standard-mode SCL.
// Notes: byte kinds order the steps of one message.
package smbhc_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int SCL_HZ = 100_000;
    localparam int QUARTER_CYC = CLK_HZ / (4 * SCL_HZ);
    localparam int TIMEOUT_MS = 28;
    localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
    localparam int SCL_HIGH_MAX_US = 50;
    localparam int SCL_HIGH_MAX_CYC = (CLK_HZ / 1_000_000) * SCL_HIGH_MAX_US;
    localparam logic [6:0] ARA_ADDR = 7'h0C;
    localparam logic [7:0] HS_CODE = 8'h08;
    localparam logic [7:0] PEC_POLY = 8'h07;
    localparam logic [7:0] PEC_INIT = 8'h00;
    localparam logic [7:0] RD_LEFT_BYTE = 8'h01;
    localparam logic [7:0] RD_LEFT_WORD = 8'h02;

    typedef enum logic [2:0] {
        OP_SEND = 3'h0,
        OP_WRW = 3'h1,
        OP_RDB = 3'h2,
        OP_RDW = 3'h3,
        OP_BLK = 3'h4,
        OP_ARA = 3'h5
    } smbhc_op_t;

    typedef enum logic [3:0] {
        K_HS = 4'h0,
        K_ADDRW = 4'h1,
        K_CMD = 4'h2,
        K_WR0 = 4'h3,
        K_WR1 = 4'h4,
        K_PECW = 4'h5,
        K_ADDRR = 4'h6,
        K_RD = 4'h7,
        K_PECR = 4'h8
    } smbhc_kind_t;

    typedef enum logic [1:0] {
        STEP_STOP = 2'h0,
        STEP_BIT = 2'h1,
        STEP_RS = 2'h2
    } smbhc_step_t;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_START = 5'b00010,
        S_BIT = 5'b00100,
        S_STOP = 5'b01000,
        S_DONE = 5'b10000
    } smbhc_state_t;

    typedef struct packed {
        smbhc_op_t op;
        logic [6:0] addr;
        logic [7:0] cmd;
        logic [15:0] wdata;
        logic pec;
        logic hs;
    } smbhc_req_t;

    typedef struct packed {
        logic nack;
        logic pec_err;
        logic timeout;
        logic [15:0] word;
    } smbhc_rsp_t;
endpackage

// file: hdl/smbhc_master.sv
// Purpose: SMBus/PMBus host master driving a power monitor over SCL/SDA.
// Assumes: open-drain pins resolved outside; pins are asynchronous inputs.
// Notes: one request at a time; SCL made here by a quarter-period divider.
`timescale 1ns/1ps
`default_nettype none

module smbhc_master #(
    parameter int QUARTER = smbhc_pkg::QUARTER_CYC,
    parameter int TIMEOUT_CYC = smbhc_pkg::TIMEOUT_CYC,
    parameter int SCL_HIGH_MAX_CYC = smbhc_pkg::SCL_HIGH_MAX_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // request
    input wire logic req_valid,
    output logic req_ready,
    input wire smbhc_pkg::smbhc_req_t req,
    // answer
    output logic rsp_valid,
    output smbhc_pkg::smbhc_rsp_t rsp,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic alert_pending,
    // bus pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic alert_n_in
);
    import smbhc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    smbhc_state_t state;
    smbhc_kind_t kind, rs_kind, nk;
    smbhc_step_t nstep;
    smbhc_req_t cur;
    logic [1:0] phase;
    logic [3:0] bcnt;
    logic [15:0] qcnt;
    logic [23:0] tocnt;
    logic [15:0] hcnt;
    logic [7:0] shreg, byte_hold, crc, rd_left;
    logic cnt_first, ack_in;
    logic [1:0] scl_sy, sda_sy, alr_sy;
    wire scl_s = scl_sy[1];
    wire sda_s = sda_sy[1];

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        logic fb;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            fb = r[7] ^ d[i];
            r = {r[6:0], 1'b0} ^ (fb ? PEC_POLY : 8'h00);
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire is_read = (cur.op == OP_RDB) || (cur.op == OP_RDW) || (cur.op == OP_BLK);
    wire rx_kind = (kind == K_RD) || (kind == K_PECR);
    wire [7:0] rem_after = cnt_first ? shreg : rd_left - 8'h01;
    wire more = (kind == K_RD) && ((rem_after != 8'h00) || cur.pec);
    wire wait_high = (phase == 2'd1) && !scl_s;
    wire advance = (qcnt == 16'h0000) && !wait_high;
    wire byte_end = (state == S_BIT) && (bcnt == 4'd8) && (phase == 2'd3) && advance;
    wire crc_skip = (kind == K_HS) || (kind == K_PECW) || (kind == K_PECR);
    wire [7:0] crc_next = crc8(crc, rx_kind ? shreg : byte_hold);
    wire stalled = (state != S_IDLE) && (qcnt == 16'h0000) && wait_high;
    wire [7:0] load_byte = (nk == K_HS) ? HS_CODE :
        (nk == K_ADDRW) ? {cur.addr, 1'b0} :
        (nk == K_ADDRR) ? {(cur.op == OP_ARA) ? ARA_ADDR : cur.addr, 1'b1} :
        (nk == K_CMD) ? cur.cmd :
        (nk == K_WR0) ? cur.wdata[7:0] :
        (nk == K_WR1) ? cur.wdata[15:8] :
        (nk == K_PECW) ? crc_next : 8'hFF;

    // what follows the byte now on the bus; on the start path nk is rs_kind
    always_comb begin
        nk = kind;
        nstep = STEP_STOP;
        if (state == S_START) begin
            nk = rs_kind;
        end else begin
            case (kind)
                K_HS: begin
                    nstep = STEP_RS;
                    nk = (cur.op == OP_ARA) ? K_ADDRR : K_ADDRW;
                end
                K_ADDRW: begin
                    if (ack_in) begin
                        nstep = STEP_BIT;
                        nk = K_CMD;
                    end
                end
                K_CMD: begin
                    if (ack_in && is_read) begin
                        nstep = STEP_RS;
                        nk = K_ADDRR;
                    end else if (ack_in && cur.op == OP_WRW) begin
                        nstep = STEP_BIT;
                        nk = K_WR0;
                    end else if (ack_in && cur.pec) begin
                        nstep = STEP_BIT;
                        nk = K_PECW;
                    end
                end
                K_WR0: begin
                    if (ack_in) begin
                        nstep = STEP_BIT;
                        nk = K_WR1;
                    end
                end
                K_WR1: begin
                    if (ack_in && cur.pec) begin
                        nstep = STEP_BIT;
                        nk = K_PECW;
                    end
                end
                K_ADDRR: begin
                    if (ack_in) begin
                        nstep = STEP_BIT;
                        nk = K_RD;
                    end
                end
                K_RD: begin
                    if (more) begin
                        nstep = STEP_BIT;
                        nk = (rem_after != 8'h00) ? K_RD : K_PECR;
                    end
                end
                default: nstep = STEP_STOP;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers; only bit 1 is read by logic
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            scl_sy <= 2'h3;
            sda_sy <= 2'h3;
            alr_sy <= 2'h3;
        end else begin
            scl_sy <= {scl_sy[0], scl_in};
            sda_sy <= {sda_sy[0], sda_in};
            alr_sy <= {alr_sy[0], alert_n_in};
        end
    end

    // quarter timer holds at zero while a slave stretches SCL low
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            qcnt <= 16'h0000;
            tocnt <= 24'h00_0000;
        end else begin
            qcnt <= (state == S_IDLE || advance) ? 16'(QUARTER - 1) :
                (qcnt != 16'h0000) ? qcnt - 16'h0001 : qcnt;
            tocnt <= stalled ? tocnt + 24'h00_0001 : 24'h00_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= S_IDLE;
            kind <= K_HS;
            rs_kind <= K_ADDRW;
            cur <= '0;
            phase <= 2'd0;
            bcnt <= 4'd0;
            shreg <= 8'h00;
            byte_hold <= 8'h00;
            crc <= PEC_INIT;
            rd_left <= 8'h00;
            cnt_first <= 1'b0;
            ack_in <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            rsp <= '0;
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            rx_valid <= 1'b0;
            if (advance) begin
                phase <= phase + 2'd1;
            end
            case (state)
                S_IDLE: begin
                    phase <= 2'd0;
                    if (req_valid) begin
                        cur <= req;
                        crc <= PEC_INIT;
                        rsp <= '0;
                        state <= S_START;
                        rs_kind <= req.hs ? K_HS : (req.op == OP_ARA) ? K_ADDRR : K_ADDRW;
                        rd_left <= (req.op == OP_RDW) ? RD_LEFT_WORD : RD_LEFT_BYTE;
                        cnt_first <= (req.op == OP_BLK);
                    end
                end
                S_START: begin
                    if (advance) begin
                        case (phase)
                            2'd0: scl_oe <= 1'b0;
                            2'd1: sda_oe <= 1'b1;
                            2'd2: scl_oe <= 1'b1;
                            default: begin
                                state <= S_BIT;
                                kind <= rs_kind;
                                bcnt <= 4'd0;
                                shreg <= load_byte;
                                byte_hold <= load_byte;
                                sda_oe <= (rs_kind != K_RD) && !load_byte[7];
                            end
                        endcase
                    end
                end
                S_BIT: begin
                    if (advance && phase == 2'd0) begin
                        scl_oe <= 1'b0;
                    end
                    if (advance && phase == 2'd2) begin
                        scl_oe <= 1'b1;
                        if (bcnt == 4'd8) begin
                            ack_in <= !sda_s;
                        end else if (rx_kind) begin
                            shreg <= {shreg[6:0], sda_s};
                        end
                    end
                    if (advance && phase == 2'd3 && bcnt != 4'd8) begin
                        bcnt <= bcnt + 4'd1;
                        if (!rx_kind) begin
                            shreg <= {shreg[6:0], 1'b0};
                        end
                        // master acks a read byte only when more follow
                        sda_oe <= (bcnt == 4'd7) ? (rx_kind && more) :
                            (!rx_kind && !shreg[6]);
                    end
                    if (byte_end) begin
                        if (!crc_skip) begin
                            crc <= crc_next;
                        end
                        if (!rx_kind && kind != K_HS && !ack_in) begin
                            rsp.nack <= 1'b1;
                        end
                        if (kind == K_PECR) begin
                            rsp.pec_err <= (shreg != crc);
                        end
                        if (kind == K_RD) begin
                            cnt_first <= 1'b0;
                            rd_left <= rem_after;
                            if (!cnt_first) begin
                                rx_valid <= 1'b1;
                                rx_byte <= shreg;
                                rsp.word <= {rsp.word[7:0], shreg};
                            end
                        end
                        kind <= nk;
                        bcnt <= 4'd0;
                        shreg <= load_byte;
                        byte_hold <= load_byte;
                        if (nstep == STEP_BIT) begin
                            sda_oe <= (nk != K_RD) && (nk != K_PECR) && !load_byte[7];
                        end else if (nstep == STEP_RS) begin
                            state <= S_START;
                            rs_kind <= nk;
                            sda_oe <= 1'b0;
                        end else begin
                            state <= S_STOP;
                            sda_oe <= 1'b1;
                        end
                    end
                end
                S_STOP: begin
                    if (advance) begin
                        case (phase)
                            2'd0: scl_oe <= 1'b0;
                            2'd1: sda_oe <= 1'b0;
                            2'd2: sda_oe <= 1'b0;
                            default: state <= S_DONE;
                        endcase
                    end
                end
                S_DONE: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
            // a slave holding SCL too long ends the attempt and frees the bus
            if (tocnt == 24'(TIMEOUT_CYC - 1)) begin
                rsp.timeout <= 1'b1;
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
                state <= S_DONE;
            end
        end
    end

    assign req_ready = (state == S_IDLE);
    assign rsp_valid = (state == S_DONE);
    assign alert_pending = !alr_sy[1];
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // checks
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hcnt <= 16'h0000;
        end else begin
            // a slave stretching SCL low is not the host holding it high
            hcnt <= (scl_oe || !scl_s || state == S_IDLE || state == S_DONE) ? 16'h0000 :
                hcnt + 16'h0001;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    chk_cmd_after_addr: assert property (
        byte_end && kind == K_ADDRW && ack_in |=> kind == K_CMD && state == S_BIT)
        else $error("command byte did not follow write address");
    chk_send_stops: assert property (
        byte_end && kind == K_CMD && ack_in && cur.op == OP_SEND && !cur.pec
        |=> state == S_STOP)
        else $error("send byte did not stop after command");
    chk_read_restart: assert property (
        byte_end && kind == K_CMD && ack_in && is_read
        |=> state == S_START && rs_kind == K_ADDRR ##1 !sda_oe)
        else $error("read did not issue repeated start");
    chk_last_nack: assert property (
        state == S_BIT && bcnt == 4'd8 && kind == K_RD && !more |-> !sda_oe)
        else $error("master acknowledged final read byte");
    chk_block_ack: assert property (
        state == S_BIT && bcnt == 4'd8 && kind == K_RD && cnt_first
        && shreg != 8'h00 |-> sda_oe)
        else $error("block count byte not acknowledged");
    chk_scl_high_time: assert property (
        hcnt < 16'(SCL_HIGH_MAX_CYC))
        else $error("scl released high too long");
    chk_hs_code: assert property (
        $rose(state == S_BIT) && kind == K_HS |-> byte_hold[7:3] == 5'b00001)
        else $error("high-speed code malformed");
    chk_ara_addr: assert property (
        $rose(state == S_BIT) && kind == K_ADDRR && cur.op == OP_ARA
        |-> byte_hold == {ARA_ADDR, 1'b1})
        else $error("alert response address wrong");
    chk_pec_byte: assert property (
        byte_end && nk == K_PECW && nstep == STEP_BIT |=> byte_hold == crc)
        else $error("sent error code differs from crc");
endmodule

`default_nettype wire

// file: dv/smbhc_dev_model.sv
// Purpose: behavioural power monitor on the far side of the host master.
// Assumes: open-drain wires resolved by the bench; one device on the bus.
// Notes: clock stretch and bad error code only when the bench asks.
`timescale 1ns/1ps
`default_nettype none
module smbhc_dev_model #(
    parameter logic [6:0] DEV_ADDR = 7'h40,
    parameter logic [7:0] BYTE_CMD = 8'h19,
    parameter logic [7:0] BLK_CMD = 8'h86,
    parameter int BLK_LEN = 6,
    parameter int TMO_CYC = 250
) (
    // clock
    input wire logic clk_sys,
    // bus
    input wire logic scl,
    input wire logic sda,
    output var logic scl_oe,
    output var logic sda_oe,
    output var logic alert_oe,
    // bench controls
    input wire logic [8:0] stretch,
    input wire logic raise_alert,
    input wire logic corrupt_pec,
    output var logic pec_fail
);
    import smbhc_pkg::*;
    typedef enum {M_IDLE, M_ADDR, M_CMD, M_WR, M_RD} smbhc_mode_t;
    smbhc_mode_t mode = M_IDLE;
    logic [15:0] regs [256];
    logic [7:0] ptr = 8'h00;
    logic [7:0] sh, txb, crc, lo;
    logic [7:0] txq [$];
    logic mack, in_msg = 1'b0, pec_sent, fault = 1'b0;
    int bitc = 0;
    int nwr = 0;

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
        end
        return r;
    endfunction

    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
        alert_oe = 1'b0;
        pec_fail = 1'b0;
        foreach (regs[i]) regs[i] = 16'h0000;
        regs[BYTE_CMD] = 16'h00b0;
    end

    // fault stays latched: nothing here clears it
    always @(posedge raise_alert) begin
        fault = 1'b1;
        alert_oe = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // framing: the post-start falling edge brings the count to zero
    always @(negedge sda) if (scl === 1'b1) begin
        if (!in_msg) crc = 8'h00;
        in_msg = 1'b1;
        mode = M_ADDR;
        bitc = -1;
        sda_oe = 1'b0;
    end

    // odd data count at stop means the last written byte was an error code
    always @(posedge sda) if (scl === 1'b1) begin
        if (mode == M_WR && nwr[0] && crc != 8'h00) pec_fail = 1'b1;
        in_msg = 1'b0;
        mode = M_IDLE;
        sda_oe = 1'b0;
    end

    always @(posedge scl) if (mode != M_IDLE) begin
        if (bitc < 8) sh = {sh[6:0], sda};
        else mack = ~sda;
    end

    always @(negedge scl) if (mode != M_IDLE) begin
        if (bitc == 7) begin
            bitc = 8;
            if (mode == M_RD) begin
                crc = crc8(crc, txb);
                sda_oe = 1'b0;
            end else begin
                take_byte();
            end
        end else if (bitc == 8) begin
            bitc = 0;
            sda_oe = 1'b0;
            if (mode == M_RD) begin
                if (mack) begin
                    next_tx();
                    sda_oe = ~txb[7];
                end else begin
                    mode = M_IDLE;
                end
            end
            if (stretch != 9'h000) begin
                // decided before the wait: the bench may change stretch meanwhile
                if (stretch >= TMO_CYC) begin
                    mode = M_IDLE;
                    in_msg = 1'b0;
                end
                scl_oe = 1'b1;
                repeat (stretch) @(posedge clk_sys);
                scl_oe = 1'b0;
            end
        end else begin
            bitc++;
            if (mode == M_RD) sda_oe = ~txb[7 - bitc];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic take_byte();
        logic ack;
        ack = 1'b1;
        crc = crc8(crc, sh);
        case (mode)
            M_ADDR: begin
                if (sh[7:1] == DEV_ADDR) begin
                    mode = sh[0] ? M_RD : M_CMD;
                    if (sh[0]) load_read();
                end else if (sh == {ARA_ADDR, 1'b1} && fault) begin
                    mode = M_RD;
                    txq.delete();
                    txq.push_back({DEV_ADDR, 1'b0});
                    alert_oe = 1'b0;
                end else begin
                    ack = 1'b0;
                    mode = M_IDLE;
                    in_msg = 1'b0;
                end
            end
            M_CMD: begin
                ptr = sh;
                nwr = 0;
                mode = M_WR;
            end
            default: begin
                if (nwr == 0) lo = sh;
                else if (nwr == 1) regs[ptr] = {sh, lo};
                nwr++;
            end
        endcase
        sda_oe = ack;
    endtask

    // pointer is only read here, so reads keep it
    task automatic load_read();
        txq.delete();
        pec_sent = 1'b0;
        if (ptr == BLK_CMD) begin
            txq.push_back(8'(BLK_LEN));
            for (int i = 0; i < BLK_LEN; i++) txq.push_back(8'h41 + 8'(i));
        end else if (ptr == BYTE_CMD) begin
            txq.push_back(regs[ptr][7:0]);
        end else begin
            txq.push_back(regs[ptr][15:8]);
            txq.push_back(regs[ptr][7:0]);
        end
    endtask

    task automatic next_tx();
        if (txq.size() != 0) begin
            txb = txq.pop_front();
        end else if (!pec_sent) begin
            txb = crc ^ {7'h00, corrupt_pec};
            pec_sent = 1'b1;
        end else begin
            txb = 8'hff;
        end
    endtask
endmodule
`default_nettype wire

// file: dv/smbus_command_slave_interface_bench.sv
// Purpose: self-checking bench of the host master against a device model.
// Assumes: shortened quarter period and timeout for run time.
// Notes: the model's state is read by hierarchy for write-side checks.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module smbus_command_slave_interface_bench;
    import smbhc_pkg::*;
    localparam logic [6:0] DEV = 7'h40;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic req_valid = 1'b0;
    smbhc_req_t req = '0;
    smbhc_rsp_t rsp;
    logic req_ready, rsp_valid, rx_valid, alert_pending;
    logic [7:0] rx_byte;
    logic m_scl_oe, m_sda_oe, d_scl_oe, d_sda_oe, d_alert_oe, pec_fail;
    logic [8:0] stretch = 9'h000;
    logic raise_alert = 1'b0;
    logic corrupt_pec = 1'b0;
    logic [7:0] rxq [$];
    int err_total = 0;
    int checked = 0;
    wire logic scl = ~(m_scl_oe | d_scl_oe);
    wire logic sda = ~(m_sda_oe | d_sda_oe);
    wire logic alert_n = ~d_alert_oe;

    initial forever #5 clk_sys = ~clk_sys;

    smbhc_master #(.QUARTER(4), .TIMEOUT_CYC(200), .SCL_HIGH_MAX_CYC(50)) u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .alert_pending(alert_pending), .scl_in(scl), .scl_out(), .scl_oe(m_scl_oe),
        .sda_in(sda), .sda_out(), .sda_oe(m_sda_oe), .alert_n_in(alert_n));

    smbhc_dev_model #(.DEV_ADDR(DEV)) u_dev (
        .clk_sys(clk_sys), .scl(scl), .sda(sda), .scl_oe(d_scl_oe), .sda_oe(d_sda_oe),
        .alert_oe(d_alert_oe), .stretch(stretch), .raise_alert(raise_alert),
        .corrupt_pec(corrupt_pec), .pec_fail(pec_fail));

    always @(posedge clk_sys) if (rx_valid === 1'b1) rxq.push_back(rx_byte);

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic run(input smbhc_op_t op, input logic [7:0] cmd, input logic [15:0] wd,
                       input logic pec, input logic hs, input logic [6:0] addr = DEV);
        int n;
        rxq.delete();
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= '{op: op, addr: addr, cmd: cmd, wdata: wd, pec: pec, hs: hs};
        n = 0;
        do begin @(negedge clk_sys); n++; end while (req_ready !== 1'b1 && n < 100);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        do begin @(negedge clk_sys); n++; end while (rsp_valid !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            err_total++;
            end_of_test();
        end
    endtask

    task automatic t_word();
        run(OP_WRW, 8'h4a, 16'ha5c3, 1'b0, 1'b0);
        `CHK(rsp.nack, 1'b0)
        `CHK(u_dev.regs[8'h4a], 16'ha5c3)
        run(OP_RDW, 8'h4a, 16'h0000, 1'b0, 1'b0);
        `CHK(rsp.word, 16'ha5c3)
        `CHK(rsp.pec_err, 1'b0)
        `CHK(rxq[0], 8'ha5)
        `CHK(u_dev.sda_oe, 1'b0)
    endtask

    task automatic t_byte_send();
        run(OP_RDB, 8'h19, 16'h0000, 1'b0, 1'b0);
        `CHK(rsp.word[7:0], 8'hb0)
        `CHK(rxq.size(), 1)
        run(OP_SEND, 8'h03, 16'hffff, 1'b0, 1'b0);
        `CHK(u_dev.ptr, 8'h03)
        `CHK(u_dev.nwr, 0)
    endtask

    task automatic t_block();
        run(OP_BLK, 8'h86, 16'h0000, 1'b0, 1'b0);
        `CHK(rxq.size(), 6)
        for (int i = 0; i < 6; i++) `CHK(rxq[i], 8'h41 + 8'(i))
        `CHK(u_dev.sda_oe, 1'b0)
    endtask

    task automatic t_pec();
        run(OP_WRW, 8'hd0, 16'h1234, 1'b1, 1'b0);
        `CHK(pec_fail, 1'b0)
        `CHK(u_dev.regs[8'hd0], 16'h1234)
        run(OP_SEND, 8'h12, 16'h0000, 1'b1, 1'b0);
        `CHK(u_dev.ptr, 8'h12)
        `CHK(pec_fail, 1'b0)
        run(OP_RDW, 8'hd0, 16'h0000, 1'b1, 1'b0);
        `CHK(rsp.word, 16'h1234)
        `CHK(rsp.pec_err, 1'b0)
        corrupt_pec <= 1'b1;
        run(OP_RDW, 8'hd0, 16'h0000, 1'b1, 1'b0);
        `CHK(rsp.pec_err, 1'b1)
        corrupt_pec <= 1'b0;
    endtask

    task automatic t_nack_hs();
        run(OP_RDW, 8'h4a, 16'h0000, 1'b0, 1'b0, 7'h22);
        `CHK(rsp.nack, 1'b1)
        `CHK({scl, sda}, 2'b11)
        run(OP_RDW, 8'h4a, 16'h0000, 1'b0, 1'b1);
        `CHK(rsp.nack, 1'b0)
        `CHK(rsp.word, 16'ha5c3)
    endtask

    task automatic t_alert();
        @(posedge clk_sys);
        raise_alert <= 1'b1;
        repeat (10) @(posedge clk_sys);
        `CHK(alert_pending, 1'b1)
        run(OP_ARA, 8'h00, 16'h0000, 1'b0, 1'b0);
        `CHK(rsp.word[7:0], {DEV, 1'b0})
        repeat (10) @(posedge clk_sys);
        `CHK(alert_pending, 1'b0)
        `CHK(u_dev.fault, 1'b1)
    endtask

    task automatic t_stall();
        stretch <= 9'h014;
        run(OP_WRW, 8'h58, 16'h0f0f, 1'b0, 1'b0);
        `CHK(rsp.timeout, 1'b0)
        `CHK(u_dev.regs[8'h58], 16'h0f0f)
        stretch <= 9'h12c;
        run(OP_WRW, 8'h6b, 16'h1111, 1'b0, 1'b0);
        `CHK(rsp.timeout, 1'b1)
        stretch <= 9'h000;
        repeat (300) @(posedge clk_sys);
        `CHK(u_dev.regs[8'h6b], 16'h0000)
        run(OP_RDW, 8'h58, 16'h0000, 1'b0, 1'b0);
        `CHK(rsp.word, 16'h0f0f)
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        t_word();
        t_byte_send();
        t_block();
        t_pec();
        t_nack_hs();
        t_alert();
        t_stall();
        end_of_test();
    end
endmodule
`default_nettype wire
